// *** src/tq_map.svh ***
// Purpose: constants for the trigger qualifier: register offsets, fields, timing
// Assumes: 40 MHz sample clock, word-indexed plain register port
// Notes: included by every module file of the block
//
// Behaviour
// - video trigger type forces trigger path coupling to AC.
// - video source offers four channels plus two external connector options.
// - normal video polarity fires on falling sync edge, inverted on rising.
// - video sync choices: all lines, line number, odd, even, all fields.
// - selected video standard sets line counting and field start lines.
// - pulse mode fires only on pulses meeting source, operator, reference width.
// - reference width spans 33 ns to 10.0 s; at 25 ns per sample the code rounds the lower end up to 2 cycles (50 ns).
// - polarity chooses positive or negative pulses for width measurement.
// - equal accepts within 5 percent of reference; unequal accepts outside.
// - less-than fires on narrower pulses, greater-than on wider pulses.
// - only pulses at least 5 ns wide must be detected; at 25 ns per sample the code may miss pulses under one period.
// - auto mode forces triggers when none seen within timeout.
// - trigger event rate is counted into a readable frequency value.
// - midpoint request sets level halfway between observed minimum and maximum.
// - force request completes acquisition at once, trigger or not.
// - while trigger view held, show trigger signal, mask all buttons but print.
// - after a trigger, ignore triggers until holdoff elapses, then re-arm.
// - holdoff step size follows the horizontal timebase setting.
// - pulse mode allows AC, DC, noise, high and low frequency block coupling.
`ifndef TQ_MAP_SVH
`define TQ_MAP_SVH

`define TQ_CLK_MHZ        40
`define TQ_CLK_KHZ        40000
// register word indexes
`define TQ_A_CTRL         4'h0
`define TQ_A_LINE         4'h1
`define TQ_A_PWREF        4'h2
`define TQ_A_HOLD_STEPS   4'h3
`define TQ_A_HOLD_STEP    4'h4
`define TQ_A_TIMEOUT      4'h5
`define TQ_A_STATUS       4'h6
`define TQ_A_FREQ         4'h7
`define TQ_A_LEVEL        4'h8
// control word fields
`define TQ_F_TYPE         1:0
`define TQ_F_AUTO         2
`define TQ_F_CPL          5:3
`define TQ_F_SRC          8:6
`define TQ_F_VINV         9
`define TQ_F_VSEL         12:10
`define TQ_F_PAL          13
`define TQ_F_PWNEG        14
`define TQ_F_PWOP         16:15
`define TQ_F_MID          17
`define TQ_F_FORCE        18
`define TQ_CTRL_KEEP      32'h0001_FFFF
// timing
`define TQ_PW_MIN_NS      33
`define TQ_PW_MAX_S       10
`define TQ_PW_MIN_CYC     ((`TQ_PW_MIN_NS * `TQ_CLK_MHZ + 999) / 1000)
`define TQ_PW_MAX_CYC     (`TQ_PW_MAX_S * `TQ_CLK_MHZ * 1000000)
`define TQ_PW_DETECT_NS   5
`define TQ_TOL_DIV        20
`define TQ_GATE_MS        1000
`define TQ_NTSC_LINES     10'd525
`define TQ_PAL_LINES      10'd625
`define TQ_PRINT_MASK     8'h01
`endif

// *** src/tq_pkg.sv ***
// Purpose: types shared by the trigger qualifier files
// Assumes: constants come from tq_map.svh
// Notes: enum order matches the register field codes
package tq_pkg;
    typedef enum logic [1:0] {TQ_TT_EDGE, TQ_TT_VIDEO, TQ_TT_PULSE} tq_type_t;
    typedef enum logic [2:0] {TQ_CPL_AC, TQ_CPL_DC, TQ_CPL_NOISE_REJ,
                              TQ_CPL_HIGH_FREQ_BLOCK, TQ_CPL_LOW_FREQ_BLOCK} tq_coupling_t;
    typedef enum logic [2:0] {TQ_SRC_INPUT_CHANNEL_ONE, TQ_SRC_INPUT_CHANNEL_TWO,
                              TQ_SRC_INPUT_CHANNEL_THREE, TQ_SRC_INPUT_CHANNEL_FOUR,
                              TQ_SRC_EXT, TQ_SRC_EXT_DIV5} tq_source_t;
    typedef enum logic [2:0] {TQ_VS_ALL_LINES, TQ_VS_LINE_NUM, TQ_VS_ODD_FIELD,
                              TQ_VS_EVEN_FIELD, TQ_VS_ALL_FIELDS} tq_vsync_t;
    typedef enum logic [1:0] {TQ_OP_EQ, TQ_OP_NE, TQ_OP_LT, TQ_OP_GT} tq_pw_op_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } tq_bus_req_t;

    typedef struct packed {
        logic [3:0] chan;
        logic       ext;
        logic       sync;
        logic       field_odd;
        logic       view;
        logic [7:0] btn;
    } tq_pins_t;

    typedef struct packed {
        logic        prev;
        logic [28:0] cnt;
        logic        hit;
    } tq_pw_state_t;

    typedef struct packed {
        logic       sync_prev;
        logic       fld_prev;
        logic       pend;
        logic [9:0] line;
        logic       hit;
    } tq_vid_state_t;

    typedef struct packed {
        tq_pins_t    pin1;
        tq_pins_t    pin2;
        logic        src_prev;
        logic [31:0] ctrl;
        logic [9:0]  line;
        logic [28:0] pwref;
        logic [15:0] hold_steps;
        logic [15:0] hold_step;
        logic [31:0] timeout;
        logic [7:0]  level;
        logic [31:0] hold_prod;
        logic [31:0] hold_cnt;
        logic [31:0] auto_cnt;
        logic [31:0] gate_cnt;
        logic [31:0] ev_cnt;
        logic [31:0] freq;
        logic [7:0]  min;
        logic [7:0]  max;
        logic [31:0] rdata;
        logic        trig;
        logic        forced;
        logic [7:0]  btn;
        logic        view_sig;
    } tq_state_t;
endpackage

// *** src/tq_pw_meas.sv ***
// Purpose: pulse width qualifier, counts active cycles and compares at trailing edge
// Assumes: sig_i already synchronised to clk_sys_i
// Notes: at 25 ns per cycle a pulse under one period may be missed
`timescale 1ns/1ps
`include "tq_map.svh"
module tq_pw_meas
(
    input  wire logic              clk_sys_i,
    input  wire logic              rstn_i,
    input  wire logic              sig_i,
    input  wire logic              neg_pol_i,
    input  wire tq_pkg::tq_pw_op_t op_i,
    input  wire logic [28:0]       ref_i,
    output logic                   hit_o
);
    import tq_pkg::*;

    tq_pw_state_t s_q;
    tq_pw_state_t s_d;
    logic         act;
    logic         trail;
    logic [28:0]  refc;
    logic [28:0]  tol;
    logic         in_band;
    logic         match;

    // clamp reference into the settable span
    always_comb
    begin
        refc = ref_i;
        if (ref_i < 29'(`TQ_PW_MIN_CYC))
            refc = 29'(`TQ_PW_MIN_CYC);
        else if (ref_i > 29'(`TQ_PW_MAX_CYC))
            refc = 29'(`TQ_PW_MAX_CYC);
    end

    // measure and judge; widths detected down to one sample
    always_comb
    begin
        s_d     = s_q;
        act     = sig_i ^ neg_pol_i;
        trail   = s_q.prev & ~act;
        tol     = refc / 29'(`TQ_TOL_DIV);
        in_band = (s_q.cnt >= refc - tol) && (s_q.cnt <= refc + tol);
        unique case (op_i)
            TQ_OP_EQ: match = in_band;
            TQ_OP_NE: match = ~in_band;
            TQ_OP_LT: match = s_q.cnt < refc;
            TQ_OP_GT: match = s_q.cnt > refc;
        endcase
        s_d.prev = act;
        if (act & ~s_q.prev)
            s_d.cnt = 29'h1;
        else if (act && s_q.cnt != 29'h1FFF_FFFF)
            s_d.cnt = s_q.cnt + 29'h1;                   // saturate, never wrap
        s_d.hit = trail & match;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign hit_o = s_q.hit;

    pw_after_trail_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        hit_o |-> $past(trail)) else $error("pulse hit without trailing edge");
    pw_lt_width_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (trail && op_i == TQ_OP_LT && s_q.cnt < refc) |=> hit_o)
        else $error("narrow pulse not accepted");
endmodule

// *** src/tq_video.sv ***
// Purpose: video sync qualifier with line and field selection
// Assumes: sync and field inputs already synchronised
// Notes: field change arms a pending flag consumed by the next sync edge
`timescale 1ns/1ps
`include "tq_map.svh"
module tq_video
(
    input  wire logic              clk_sys_i,
    input  wire logic              rstn_i,
    input  wire logic              sync_i,
    input  wire logic              field_odd_i,
    input  wire logic              inverted_i,
    input  wire tq_pkg::tq_vsync_t sel_i,
    input  wire logic              pal_i,
    input  wire logic [9:0]        line_num_i,
    output logic                   hit_o
);
    import tq_pkg::*;

    tq_vid_state_t s_q;
    tq_vid_state_t s_d;
    logic          edge_s;
    logic [9:0]    total;
    logic [9:0]    nxt;

    // line count and selection
    always_comb
    begin
        s_d    = s_q;
        edge_s = inverted_i ? (sync_i & ~s_q.sync_prev) : (~sync_i & s_q.sync_prev);
        total  = pal_i ? `TQ_PAL_LINES : `TQ_NTSC_LINES;
        if (s_q.pend)
            nxt = field_odd_i ? 10'h001 : 10'((total >> 1) + 10'h2);
        else
            nxt = (s_q.line >= total) ? 10'h001 : s_q.line + 10'h001;
        s_d.sync_prev = sync_i;
        s_d.fld_prev  = field_odd_i;
        if (field_odd_i != s_q.fld_prev)
            s_d.pend = 1'b1;
        s_d.hit = 1'b0;
        if (edge_s)
        begin
            s_d.line = nxt;
            s_d.pend = 1'b0;
            unique case (sel_i)
                TQ_VS_ALL_LINES:  s_d.hit = 1'b1;
                TQ_VS_LINE_NUM:   s_d.hit = (nxt == line_num_i);
                TQ_VS_ODD_FIELD:  s_d.hit = s_q.pend & field_odd_i;
                TQ_VS_EVEN_FIELD: s_d.hit = s_q.pend & ~field_odd_i;
                TQ_VS_ALL_FIELDS: s_d.hit = s_q.pend;
                default:          s_d.hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign hit_o = s_q.hit;

    vid_edge_pol_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        hit_o |-> (inverted_i ? $past(sync_i) : !$past(sync_i)))
        else $error("video hit on wrong sync edge");
endmodule

// *** src/tq_top.sv ***
// Purpose: trigger qualifier top: source routing, coupling, holdoff, auto, force, readouts
// Assumes: front-end pins are asynchronous; ADC sample bus is on clk_sys_i
// Notes: registers on a plain word-indexed port, read data one cycle after the strobe
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "tq_map.svh"
module tq_top
#(
    parameter int unsigned GATE_CYC = `TQ_GATE_MS * `TQ_CLK_KHZ
)
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 rstn_i,
    input  wire tq_pkg::tq_bus_req_t  bus_i,
    output logic [31:0]               rdata_o,
    input  wire tq_pkg::tq_pins_t     pins_i,
    input  wire logic [7:0]           sample_i,
    output tq_pkg::tq_coupling_t      coupling_o,
    output logic                      ext_route_o,
    output logic                      ext_atten_o,
    output logic [7:0]                level_o,
    output logic                      trig_o,
    output logic                      forced_o,
    output logic                      view_o,
    output logic                      view_sig_o,
    output logic [7:0]                btn_o
);
    import tq_pkg::*;

    tq_state_t    s_q;
    tq_state_t    s_d;
    tq_type_t     ttype;
    tq_source_t   src;
    tq_coupling_t cpl;
    logic         src_sig;
    logic         vid_hit;
    logic         pw_hit;
    logic         qual_hit;
    logic         armed;
    logic         accept;
    logic         auto_fire;
    logic         force_req;
    logic         mid_req;
    logic         fire;
    logic         ctrl_wr;

    // halfway point of two levels, carried one bit wider to avoid overflow
    function automatic logic [7:0] tq_mid(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] sum;
        sum    = {1'b0, a} + {1'b0, b};
        tq_mid = sum[8:1];
    endfunction

    // saturating increment for the free counters
    function automatic logic [31:0] tq_inc(input logic [31:0] v);
        tq_inc = (v == 32'hFFFF_FFFF) ? v : v + 32'h1;
    endfunction

    // decoded control fields
    always_comb
    begin
        ttype     = tq_type_t'(s_q.ctrl[`TQ_F_TYPE]);
        src       = tq_source_t'(s_q.ctrl[`TQ_F_SRC]);
        cpl       = tq_coupling_t'(s_q.ctrl[`TQ_F_CPL]);
        ctrl_wr   = bus_i.wr && bus_i.addr == `TQ_A_CTRL;
        force_req = ctrl_wr && bus_i.wdata[`TQ_F_FORCE];
        mid_req   = ctrl_wr && bus_i.wdata[`TQ_F_MID];
    end

    // source select: the two external choices both take the connector input
    always_comb
    begin
        unique case (src)
            TQ_SRC_INPUT_CHANNEL_ONE:   src_sig = s_q.pin2.chan[0];
            TQ_SRC_INPUT_CHANNEL_TWO:   src_sig = s_q.pin2.chan[1];
            TQ_SRC_INPUT_CHANNEL_THREE: src_sig = s_q.pin2.chan[2];
            TQ_SRC_INPUT_CHANNEL_FOUR:  src_sig = s_q.pin2.chan[3];
            TQ_SRC_EXT:                 src_sig = s_q.pin2.ext;
            TQ_SRC_EXT_DIV5:            src_sig = s_q.pin2.ext;
            default:                    src_sig = s_q.pin2.ext;
        endcase
    end

    tq_video u_video
    (
        .clk_sys_i   (clk_sys_i),
        .rstn_i      (rstn_i),
        .sync_i      (s_q.pin2.sync),
        .field_odd_i (s_q.pin2.field_odd),
        .inverted_i  (s_q.ctrl[`TQ_F_VINV]),
        .sel_i       (tq_vsync_t'(s_q.ctrl[`TQ_F_VSEL])),
        .pal_i       (s_q.ctrl[`TQ_F_PAL]),
        .line_num_i  (s_q.line),
        .hit_o       (vid_hit)
    );

    tq_pw_meas u_pw
    (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .sig_i     (src_sig),
        .neg_pol_i (s_q.ctrl[`TQ_F_PWNEG]),
        .op_i      (tq_pw_op_t'(s_q.ctrl[`TQ_F_PWOP])),
        .ref_i     (s_q.pwref),
        .hit_o     (pw_hit)
    );

    // qualify, gate by holdoff, and pick the firing cause
    always_comb
    begin
        unique case (ttype)
            TQ_TT_VIDEO: qual_hit = vid_hit;
            TQ_TT_PULSE: qual_hit = pw_hit;
            TQ_TT_EDGE:  qual_hit = src_sig & ~s_q.src_prev;
            default:     qual_hit = 1'b0;
        endcase
        armed     = (s_q.hold_cnt == 32'h0);
        accept    = qual_hit & armed;
        auto_fire = s_q.ctrl[`TQ_F_AUTO] && armed &&
                    (s_q.auto_cnt >= s_q.timeout);
        // a force does not wait for holdoff: the acquisition must end now
        fire      = accept | auto_fire | force_req;
    end

    // next state
    always_comb
    begin
        s_d          = s_q;
        s_d.pin1     = pins_i;
        s_d.pin2     = s_q.pin1;
        s_d.src_prev = src_sig;
        s_d.trig     = fire;
        s_d.forced   = (auto_fire | force_req) & ~accept;

        // register writes; command bits are pulses and are not stored
        if (bus_i.wr)
        begin
            unique case (bus_i.addr)
                `TQ_A_CTRL:       s_d.ctrl       = bus_i.wdata & `TQ_CTRL_KEEP;
                `TQ_A_LINE:       s_d.line       = bus_i.wdata[9:0];
                `TQ_A_PWREF:      s_d.pwref      = bus_i.wdata[28:0];
                `TQ_A_HOLD_STEPS: s_d.hold_steps = bus_i.wdata[15:0];
                `TQ_A_HOLD_STEP:  s_d.hold_step  = bus_i.wdata[15:0];
                `TQ_A_TIMEOUT:    s_d.timeout    = bus_i.wdata;
                `TQ_A_LEVEL:      s_d.level      = bus_i.wdata[7:0];
                default:          ;
            endcase
        end

        // holdoff length is steps times the timebase-dependent step size
        s_d.hold_prod = 32'(s_q.hold_steps * s_q.hold_step);
        if (fire)
            s_d.hold_cnt = s_q.hold_prod;
        else if (s_q.hold_cnt != 32'h0)
            s_d.hold_cnt = s_q.hold_cnt - 32'h1;

        // auto timeout restarts on every trigger of any kind
        s_d.auto_cnt = fire ? 32'h0 : tq_inc(s_q.auto_cnt);

        // event rate over a fixed gate; counts triggerable events, not accepts
        if (s_q.gate_cnt == 32'(GATE_CYC - 1))
        begin
            s_d.gate_cnt = 32'h0;
            s_d.freq     = s_q.ev_cnt;
            s_d.ev_cnt   = {31'h0, qual_hit};
        end
        else
        begin
            s_d.gate_cnt = s_q.gate_cnt + 32'h1;
            if (qual_hit)
                s_d.ev_cnt = tq_inc(s_q.ev_cnt);
        end

        // extremes of the signal; a request uses them and starts a new watch
        if (sample_i < s_q.min)
            s_d.min = sample_i;
        if (sample_i > s_q.max)
            s_d.max = sample_i;
        if (mid_req)
        begin
            s_d.level = tq_mid(s_q.min, s_q.max);
            s_d.min   = sample_i;
            s_d.max   = sample_i;
        end

        // while view is held only print passes; knobs are not on this path
        s_d.btn      = s_q.pin2.view ? (s_q.pin2.btn & `TQ_PRINT_MASK) : s_q.pin2.btn;
        s_d.view_sig = s_q.pin2.view & src_sig;

        // read data appears the cycle after the strobe, zero otherwise
        s_d.rdata = 32'h0;
        if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                `TQ_A_CTRL:       s_d.rdata = s_q.ctrl;
                `TQ_A_LINE:       s_d.rdata = {22'h0, s_q.line};
                `TQ_A_PWREF:      s_d.rdata = {3'h0, s_q.pwref};
                `TQ_A_HOLD_STEPS: s_d.rdata = {16'h0, s_q.hold_steps};
                `TQ_A_HOLD_STEP:  s_d.rdata = {16'h0, s_q.hold_step};
                `TQ_A_TIMEOUT:    s_d.rdata = s_q.timeout;
                `TQ_A_STATUS:     s_d.rdata = {29'h0, s_q.pin2.view, armed, ~armed};
                `TQ_A_FREQ:       s_d.rdata = s_q.freq;
                `TQ_A_LEVEL:      s_d.rdata = {24'h0, s_q.level};
                default:          s_d.rdata = 32'h0;
            endcase
        end
    end

    // single state register; min starts high so the first sample wins
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            s_q         <= '0;
            s_q.min     <= 8'hFF;
            s_q.timeout <= 32'hFFFF_FFFF;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // video always runs AC on the trigger path; pulse mode keeps the choice
    always_comb
    begin
        if (ttype == TQ_TT_VIDEO)
            coupling_o = TQ_CPL_AC;
        else
            coupling_o = cpl;
    end

    assign ext_route_o = (src == TQ_SRC_EXT) || (src == TQ_SRC_EXT_DIV5);
    assign ext_atten_o = (src == TQ_SRC_EXT_DIV5);
    assign level_o     = s_q.level;
    assign trig_o      = s_q.trig;
    assign forced_o    = s_q.forced;
    assign view_o      = s_q.pin2.view;
    assign view_sig_o  = s_q.view_sig;
    assign btn_o       = s_q.btn;
    assign rdata_o     = s_q.rdata;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    video_ac_cpl_a: assert property (ttype == TQ_TT_VIDEO |-> coupling_o == TQ_CPL_AC)
        else $error("video without AC coupling");
    ext_route_a: assert property (src_sig == s_q.pin2.ext || !ext_route_o)
        else $error("external choice not routed from connector");
    holdoff_block_a: assert property ((trig_o && !forced_o) |-> $past(armed))
        else $error("trigger accepted during holdoff");
    holdoff_load_a: assert property (fire |=> s_q.hold_cnt == $past(s_q.hold_prod))
        else $error("holdoff not loaded on trigger");
    holdoff_dec_a: assert property ((!fire && s_q.hold_cnt != 32'h0) |=>
        s_q.hold_cnt == $past(s_q.hold_cnt) - 32'h1)
        else $error("holdoff not counting down");
    force_now_a: assert property (force_req |=> trig_o)
        else $error("force did not complete at once");
    auto_fire_a: assert property ((s_q.ctrl[`TQ_F_AUTO] && armed && s_q.auto_cnt >= s_q.timeout)
        |=> trig_o && s_q.auto_cnt == 32'h0)
        else $error("auto timeout without forced trigger");
    midpoint_a: assert property (mid_req |=> level_o == tq_mid($past(s_q.min), $past(s_q.max)))
        else $error("midpoint level wrong");
    view_mask_a: assert property (view_o |=> (btn_o & ~`TQ_PRINT_MASK) == 8'h00)
        else $error("button passed during trigger view");
    read_late_a: assert property (!bus_i.rd |=> rdata_o == 32'h0)
        else $error("read data outside its cycle");

    cov_video_trig_c: cover property (ttype == TQ_TT_VIDEO && accept);
    cov_pulse_trig_c: cover property (ttype == TQ_TT_PULSE && accept);
    cov_auto_c:       cover property (auto_fire && !accept);
    cov_hold_drop_c:  cover property (qual_hit && !armed);
endmodule

// *** verification/tq_fe_model.sv ***
// Purpose: front-end stand-in that drives comparator, view and button pins
// Assumes: one pulse request at a time on input channel one
// Notes: the channel idles low; sync follows it, the field line stays low
`timescale 1ns/1ps
module tq_fe_model
(
    input  wire logic        clk_sys_i,
    input  wire logic        go_i,
    input  wire logic [15:0] width_i,
    input  wire logic [7:0]  btn_i,
    input  wire logic        view_i,
    output tq_pkg::tq_pins_t pins_o
);
    logic [15:0] left_q = 16'h0000;
    // channel one stays high for exactly width_i cycles per request
    always_ff @(posedge clk_sys_i)
        left_q <= go_i ? width_i : left_q - 16'(left_q != 16'h0000);
    // view and buttons pass straight through, the block syncs them itself
    // sync copies the pulse so one request also gives one sync edge pair
    assign pins_o = '{chan: {3'h0, left_q != 16'h0000}, ext: 1'b0, sync: left_q != 16'h0000,
                      field_odd: 1'b0, view: view_i, btn: btn_i};
endmodule

// *** verification/tb_top.sv ***
// Purpose: directed bench for the trigger qualifier top
// Assumes: gate window shortened to 100 cycles
// Notes: widths are in 25 ns clock cycles
`timescale 1ns/1ps
module tb_top;
    import tq_pkg::*;
    logic             clk_sys_i = 1'b0;
    logic             rstn_i = 1'b0;
    tq_bus_req_t      bus_i = '0;
    tq_pins_t         pins_i;
    logic [7:0]       sample_i = 8'h20;
    logic [7:0]       btn = 8'h00;
    logic             go = 1'b0;
    logic             view = 1'b0;
    logic [15:0]      width = 16'h0000;
    logic [31:0]      rdata_o;
    tq_coupling_t     coupling_o;
    logic             ext_route_o, ext_atten_o, trig_o, forced_o, view_o, view_sig_o;
    logic [7:0]       level_o, btn_o;
    logic [31:0]      d;
    int               bad_count = 0;
    int               num_checks = 0;
    tq_top #(.GATE_CYC(100)) dut_u (.clk_sys_i, .rstn_i, .bus_i, .rdata_o, .pins_i,
        .sample_i, .coupling_o, .ext_route_o, .ext_atten_o, .level_o, .trig_o,
        .forced_o, .view_o, .view_sig_o, .btn_o);
    tq_fe_model fe_u (.clk_sys_i, .go_i(go), .width_i(width), .btn_i(btn),
        .view_i(view), .pins_o(pins_i));
    // free-running sample clock
    initial
        forever #12.5 clk_sys_i = ~clk_sys_i;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // one idle edge after each strobe, so the next request never shares a step with the release
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk_sys_i);
        bus_i <= '0;
        @(posedge clk_sys_i);
    endtask
    // read data is taken mid-cycle in the single cycle after the strobe
    task automatic rd(input logic [3:0] a);
        bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk_sys_i);
        bus_i <= '0;
        @(negedge clk_sys_i);
        d = rdata_o;
        @(posedge clk_sys_i);
    endtask
    // one pulse of w cycles, then count triggers over a bounded window
    task automatic pulse(input logic [15:0] w, input int e);
        int c;
        c = 0;
        width <= w;
        go <= 1'b1;
        @(posedge clk_sys_i);
        go <= 1'b0;
        repeat (int'(w) + 20)
        begin
            @(posedge clk_sys_i);
            c += int'(trig_o === 1'b1);
        end
        chk("trig count", 32'(e), 32'(c));
    endtask
    task automatic s_reset;
        rd(4'h5);
        chk("timeout", 32'hFFFF_FFFF, d);
        rd(4'hF);
        chk("unmapped", 32'h0, d);
    endtask
    task automatic s_video;
        wr(4'h0, 32'h0000_0149);
        chk("coupling", 32'(TQ_CPL_AC), 32'(coupling_o));
        chk("ext", 32'h3, {30'h0, ext_route_o, ext_atten_o});
        pulse(16'd10, 1);
        wr(4'h1, 32'd2);
        wr(4'h0, 32'h0000_0401);
        pulse(16'd10, 1);
        pulse(16'd10, 0);
    endtask
    // every comparison operator, each at an edge of its band
    task automatic s_pulse;
        logic [31:0] op [7] = '{32'hA, 32'hA, 32'h1_000A, 32'h1_000A, 32'h1_800A, 32'h800A, 32'h800A};
        logic [15:0] w [7] = '{16'd42, 16'd43, 16'd39, 16'd40, 16'd41, 16'd38, 16'd37};
        int e [7] = '{1, 0, 1, 0, 1, 0, 1};
        for (int i = 0; i < 7; i++)
        begin
            wr(4'h0, op[i]);
            wr(4'h2, 32'd40);
            chk("pw coupling", 32'(TQ_CPL_DC), 32'(coupling_o));
            pulse(w[i], e[i]);
        end
    endtask
    task automatic s_force_hold;
        wr(4'h3, 32'd1);
        wr(4'h4, 32'd300);
        // force written by hand so the one-cycle trigger is seen while it stands
        bus_i <= '{wr: 1'b1, rd: 1'b0, addr: 4'h0, wdata: 32'h0004_000A};
        @(posedge clk_sys_i);
        bus_i <= '0;
        @(negedge clk_sys_i);
        chk("forced", 32'h3, {30'h0, trig_o, forced_o});
        @(posedge clk_sys_i);
        pulse(16'd42, 0);
        repeat (260) @(posedge clk_sys_i);
        pulse(16'd42, 1);
        wr(4'h3, 32'd0);
    endtask
    // one rising edge every 25 cycles gives exactly 4 per 100-cycle gate
    task automatic s_freq;
        wr(4'h0, 32'h0);
        repeat (12)
        begin
            width <= 16'd10;
            go <= 1'b1;
            @(posedge clk_sys_i);
            go <= 1'b0;
            repeat (24) @(posedge clk_sys_i);
        end
        rd(4'h7);
        chk("freq", 32'd4, d);
    endtask
    task automatic s_view_mid;
        btn <= 8'hFF;
        view <= 1'b1;
        sample_i <= 8'hA0;
        repeat (4) @(posedge clk_sys_i);
        chk("btn", 32'h01, 32'(btn_o));
        chk("view", 32'h1, {31'h0, view_o});
        width <= 16'd20;
        go <= 1'b1;
        @(posedge clk_sys_i);
        go <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        chk("view sig", 32'h1, {31'h0, view_sig_o});
        wr(4'h0, 32'h0002_0000);
        @(negedge clk_sys_i);
        chk("level", 32'h60, 32'(level_o));
    endtask
    // the verdict and the end of the run
    task automatic results;
        if (bad_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        s_reset();
        s_video();
        s_pulse();
        s_force_hold();
        s_freq();
        s_view_mid();
        results();
    end
    // hang guard
    initial
    begin
        repeat (100000) @(posedge clk_sys_i);
        bad_count++;
        results();
    end
endmodule
